// ===== sir_responder.sv
// Identity and pack-status command responder behind the gauge's SMBus slave port.
// Assumes the SMBus engine hands over read commands and pulls answer bytes one at a time.
//
// What this block does
// - Spec word nibbles packed, scale exponents zero
// - Date word encodes year, month, day packed
// - Date fields: day 5b, month 4b, year 7b
// - Serial word taken from flash bytes 0x0a-0x0b
// - Command 0x20 returns manufacturer name block
// - Extended option appends extended manufacturer name
// - Command 0x21 returns device name block
// - Extended option appends extended device name
// - Command 0x22 returns chemistry string block
// - Command 0x23 returns ten configuration bytes, front-end status and pending EDV
// - Command 0x2f: status low, pack config high
// - Bit 7 shows pack inserted
// - Bit 6 shows second end-of-discharge reached
// - Bit 5 shows sealed state
// - Bit 4 shows discharge qualified for update
// - Bit 3 shows front-end link failure
// - Bit 2 follows permanent failure flag
// - Bit 1 live secondary over fault
// - Bit 0 live secondary under fault
// - Cell voltages on relocatable commands, other NACKed
// - Spec word low byte comes from flash 0x07, high byte is zero
`timescale 1ns/1ns
module sir_responder
(
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst,
  // Command from SMBus engine
  input  wire logic               cmd_valid,
  input  wire logic [7:0]         cmd_code,
  input  wire logic               xfer_abort,
  // Answer bytes to SMBus engine
  output logic                    resp_valid,
  output logic [7:0]              resp_byte,
  output logic                    resp_last,
  input  wire logic               resp_ready,
  output logic                    resp_nack,
  // Data flash read port
  output logic                    flash_rd_en,
  output logic [8:0]              flash_addr,
  input  wire logic [7:0]         flash_rd_data,
  // Options
  input  wire logic               extended_string_enable,
  input  wire logic               cell_cmd_relocate,
  // Gauge state, same clock
  input  wire sir_pkg::sir_gauge_t gauge,
  // Pins from the pack and protection front end
  input  wire logic               pack_inserted_pin,
  input  wire logic               secondary_over_fault_pin,
  input  wire logic               secondary_under_fault_pin
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [2:0] pins_sync;

  sir_sync #(.WIDTH(3)) u_sync
  (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({pack_inserted_pin, secondary_over_fault_pin, secondary_under_fault_pin}),
    .sync_out (pins_sync)
  );

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic cell_cmd_hit(input logic [7:0] cmd, input logic reloc);
    logic [7:0] base;
    base = reloc ? sir_pkg::CMD_CELL_ALT : sir_pkg::CMD_CELL_BASE;
    cell_cmd_hit = (cmd[7:2] == base[7:2]);
  endfunction : cell_cmd_hit

  function automatic logic supported(input logic [7:0] cmd, input logic reloc);
    case (cmd)
      sir_pkg::CMD_SPEC_INFO,
      sir_pkg::CMD_MFG_DATE,
      sir_pkg::CMD_SERIAL,
      sir_pkg::CMD_MFR_NAME,
      sir_pkg::CMD_DEV_NAME,
      sir_pkg::CMD_CHEMISTRY,
      sir_pkg::CMD_MFR_DATA,
      sir_pkg::CMD_PACK_STAT: supported = 1'b1;
      default:                supported = cell_cmd_hit(cmd, reloc);
    endcase
  endfunction : supported

  function automatic logic is_string(input logic [7:0] cmd);
    is_string = (cmd == sir_pkg::CMD_MFR_NAME) || (cmd == sir_pkg::CMD_DEV_NAME)
             || (cmd == sir_pkg::CMD_CHEMISTRY);
  endfunction : is_string

  function automatic logic [4:0] max_chars(input logic [7:0] cmd);
    case (cmd)
      sir_pkg::CMD_MFR_NAME: max_chars = sir_pkg::MAX_MFR_NAME;
      sir_pkg::CMD_DEV_NAME: max_chars = sir_pkg::MAX_DEV_NAME;
      default:               max_chars = sir_pkg::MAX_CHEMISTRY;
    endcase
  endfunction : max_chars

  // Byte source for one position of the answer
  function automatic sir_pkg::sir_src_t byte_source(
    input logic [7:0] cmd,
    input logic [4:0] idx,
    input logic [4:0] chars
  );
    sir_pkg::sir_src_t s;
    logic [8:0]        base;
    logic [8:0]        ext_base;
    s.sel    = sir_pkg::LV_FLASH;
    s.hi     = idx[0];
    s.addr   = '0;
    base     = sir_pkg::DF_CHEMISTRY;
    ext_base = sir_pkg::DF_EXT_DEV;
    case (cmd)
      sir_pkg::CMD_SPEC_INFO:
      begin
        // Scale nibbles forced zero whatever flash holds
        if (idx == 5'h00)
          s.addr = sir_pkg::DF_SPEC_LO;
        else
          s.sel = sir_pkg::LV_SCALE;
      end
      sir_pkg::CMD_MFG_DATE:
        s.addr = (idx == 5'h00) ? sir_pkg::DF_DATE_LO : sir_pkg::DF_DATE_HI;
      sir_pkg::CMD_SERIAL:
        s.addr = (idx == 5'h00) ? sir_pkg::DF_SERIAL_LO : sir_pkg::DF_SERIAL_HI;
      sir_pkg::CMD_MFR_NAME,
      sir_pkg::CMD_DEV_NAME,
      sir_pkg::CMD_CHEMISTRY:
      begin
        if (cmd == sir_pkg::CMD_MFR_NAME)
        begin
          base     = sir_pkg::DF_MFR_NAME;
          ext_base = sir_pkg::DF_EXT_MFR;
        end
        else if (cmd == sir_pkg::CMD_DEV_NAME)
          base = sir_pkg::DF_DEV_NAME;
        // Length byte sits at the base, characters follow it
        if (idx <= chars)
          s.addr = 9'(base + {4'h0, idx});
        else
          s.addr = 9'(ext_base + {4'h0, 5'(idx - chars - 5'h01)});
      end
      sir_pkg::CMD_MFR_DATA:
      begin
        if (idx == 5'h00)
          s.sel = sir_pkg::LV_MDLEN;
        else if (idx <= sir_pkg::MFR_DATA_FLASH)
          s.addr = 9'(sir_pkg::DF_PACK_CFG + {4'h0, 5'(idx - 5'h01)});
        else if (idx == 5'(sir_pkg::MFR_DATA_FLASH + 5'h01))
          s.sel = sir_pkg::LV_AFE;
        else if (idx == 5'(sir_pkg::MFR_DATA_FLASH + 5'h02))
          s.sel = sir_pkg::LV_EDV_LO;
        else
          s.sel = sir_pkg::LV_EDV_HI;
      end
      sir_pkg::CMD_PACK_STAT:
      begin
        if (idx == 5'h00)
          s.sel = sir_pkg::LV_STATUS;
        else
          s.addr = sir_pkg::DF_PACK_CFG;
      end
      default:
        s.sel = sir_pkg::LV_CELL;
    endcase
    byte_source = s;
  endfunction : byte_source

  // ==========================================================================
  // Pack status byte, live
  // ==========================================================================
  logic [7:0] pack_status;

  always_comb
  begin
    pack_status                    = '0;
    pack_status[sir_pkg::PS_HOST]  = pins_sync[2];
    pack_status[sir_pkg::PS_EOD2]  = gauge.end_discharge_level2;
    pack_status[sir_pkg::PS_SEAL]  = gauge.sealed;
    pack_status[sir_pkg::PS_QLF]   = gauge.discharge_qualified;
    pack_status[sir_pkg::PS_AFE]   = gauge.front_end_link_failed;
    // Follows the flag itself, so it clears only with the flag
    pack_status[sir_pkg::PS_PFL]   = (gauge.permanent_failure == sir_pkg::PF_FLAG_SET);
    pack_status[sir_pkg::PS_OVER]  = pins_sync[1];
    pack_status[sir_pkg::PS_UNDER] = pins_sync[0];
  end

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  sir_pkg::sir_regs_t q;
  sir_pkg::sir_regs_t n;

  always_comb
  begin
    sir_pkg::sir_src_t src;
    logic [15:0]       cell_mv;
    logic [7:0]        live;
    logic [4:0]        clamp;
    logic [4:0]        new_total;
    logic [7:0]        outb;
    src       = byte_source(q.cmd, q.idx, q.chars);
    cell_mv   = gauge.cell_voltages[2'(2'h3 - q.cmd[1:0])];
    live      = '0;
    clamp     = '0;
    new_total = q.total;
    outb      = flash_rd_data;
    n             = q;
    n.resp_nack   = 1'b0;
    n.flash_rd_en = 1'b0;

    case (src.sel)
      sir_pkg::LV_SCALE:  live = {sir_pkg::SCALE_EXP_ZERO, sir_pkg::SCALE_EXP_ZERO};
      sir_pkg::LV_STATUS: live = pack_status;
      sir_pkg::LV_AFE:    live = gauge.front_end_status;
      sir_pkg::LV_EDV_LO: live = gauge.pending_edv[7:0];
      sir_pkg::LV_EDV_HI: live = gauge.pending_edv[15:8];
      sir_pkg::LV_CELL:   live = src.hi ? cell_mv[15:8] : cell_mv[7:0];
      sir_pkg::LV_MDLEN:  live = sir_pkg::MFR_DATA_LEN;
      default:            live = '0;
    endcase

    case (q.st)
      sir_pkg::ST_IDLE:
      begin
        n.resp_valid = 1'b0;
        n.resp_last  = 1'b0;
        if (cmd_valid)
        begin
          if (supported(cmd_code, cell_cmd_relocate))
          begin
            n.cmd   = cmd_code;
            n.idx   = '0;
            n.chars = '0;
            n.ext   = extended_string_enable
                   && ((cmd_code == sir_pkg::CMD_MFR_NAME) || (cmd_code == sir_pkg::CMD_DEV_NAME));
            n.total = (cmd_code == sir_pkg::CMD_MFR_DATA) ? sir_pkg::MFR_DATA_BYTES
                                                           : sir_pkg::WORD_BYTES;
            n.st    = sir_pkg::ST_LOAD;
          end
          else
            n.resp_nack = 1'b1;
        end
      end
      sir_pkg::ST_LOAD:
      begin
        if (src.sel == sir_pkg::LV_FLASH)
        begin
          n.flash_addr  = src.addr;
          n.flash_rd_en = 1'b1;
          n.st          = sir_pkg::ST_REQ;
        end
        else
        begin
          n.resp_byte  = live;
          n.resp_valid = 1'b1;
          n.resp_last  = (q.idx == 5'(q.total - 5'h01));
          n.st         = sir_pkg::ST_SEND;
        end
      end
      sir_pkg::ST_REQ:
        n.st = sir_pkg::ST_CAPT;
      sir_pkg::ST_CAPT:
      begin
        if (is_string(q.cmd) && (q.idx == 5'h00))
        begin
          // Oversized stored lengths are clamped so the block never runs past its field
          clamp     = (flash_rd_data > {3'h0, max_chars(q.cmd)}) ? max_chars(q.cmd)
                                                                 : flash_rd_data[4:0];
          new_total = 5'(5'h01 + clamp + (q.ext ? sir_pkg::EXT_STR_LEN : 5'h00));
          outb      = {3'h0, 5'(new_total - 5'h01)};
          n.chars   = clamp;
          n.total   = new_total;
        end
        n.resp_byte  = outb;
        n.resp_valid = 1'b1;
        n.resp_last  = (q.idx == 5'(new_total - 5'h01));
        n.st         = sir_pkg::ST_SEND;
      end
      sir_pkg::ST_SEND:
      begin
        if (resp_ready)
        begin
          n.resp_valid = 1'b0;
          n.resp_last  = 1'b0;
          if (q.resp_last)
            n.st = sir_pkg::ST_IDLE;
          else
          begin
            n.idx = 5'(q.idx + 5'h01);
            n.st  = sir_pkg::ST_LOAD;
          end
        end
      end
      default:
        n = sir_pkg::REGS_RESET;
    endcase

    // Stop or repeated start from the engine drops any answer in flight
    if (xfer_abort)
    begin
      n.st          = sir_pkg::ST_IDLE;
      n.resp_valid  = 1'b0;
      n.resp_last   = 1'b0;
      n.flash_rd_en = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      q <= sir_pkg::REGS_RESET;
    else
      q <= n;
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign resp_valid  = q.resp_valid;
  assign resp_byte   = q.resp_byte;
  assign resp_last   = q.resp_last;
  assign resp_nack   = q.resp_nack;
  assign flash_rd_en = q.flash_rd_en;
  assign flash_addr  = q.flash_addr;

endmodule : sir_responder

// ===== sir_pkg.sv
// Constants, command codes, flash layout and carrier types for the identity/status responder.
// Assumes a byte-wide internal data flash with one cycle of read latency.
package sir_pkg;

  // ==========================================================================
  // Command codes
  // ==========================================================================
  localparam logic [7:0] CMD_SPEC_INFO  = 8'h1A;
  localparam logic [7:0] CMD_MFG_DATE   = 8'h1B;
  localparam logic [7:0] CMD_SERIAL     = 8'h1C;
  localparam logic [7:0] CMD_MFR_NAME   = 8'h20;
  localparam logic [7:0] CMD_DEV_NAME   = 8'h21;
  localparam logic [7:0] CMD_CHEMISTRY  = 8'h22;
  localparam logic [7:0] CMD_MFR_DATA   = 8'h23;
  localparam logic [7:0] CMD_PACK_STAT  = 8'h2F;
  localparam logic [7:0] CMD_CELL_BASE  = 8'h3C;
  localparam logic [7:0] CMD_CELL_ALT   = 8'h38;

  // ==========================================================================
  // Data flash addresses (high byte of a word at the lower address)
  // ==========================================================================
  localparam logic [8:0] DF_SPEC_LO     = 9'h007;
  localparam logic [8:0] DF_DATE_HI     = 9'h008;
  localparam logic [8:0] DF_DATE_LO     = 9'h009;
  localparam logic [8:0] DF_SERIAL_HI   = 9'h00A;
  localparam logic [8:0] DF_SERIAL_LO   = 9'h00B;
  localparam logic [8:0] DF_MFR_NAME    = 9'h00E;
  localparam logic [8:0] DF_DEV_NAME    = 9'h01A;
  localparam logic [8:0] DF_CHEMISTRY   = 9'h022;
  localparam logic [8:0] DF_PACK_CFG    = 9'h028;
  localparam logic [8:0] DF_EXT_MFR     = 9'h151;
  localparam logic [8:0] DF_EXT_DEV     = 9'h141;

  // ==========================================================================
  // Lengths and field values
  // ==========================================================================
  localparam logic [4:0] MAX_MFR_NAME   = 5'h0B;
  localparam logic [4:0] MAX_DEV_NAME   = 5'h07;
  localparam logic [4:0] MAX_CHEMISTRY  = 5'h04;
  localparam logic [4:0] EXT_STR_LEN    = 5'h0F;
  localparam logic [4:0] WORD_BYTES     = 5'h02;
  localparam logic [4:0] MFR_DATA_FLASH = 5'h0A;
  localparam logic [4:0] MFR_DATA_BYTES = 5'h0E;
  localparam logic [7:0] MFR_DATA_LEN   = 8'h0D;
  localparam logic [3:0] SCALE_EXP_ZERO = 4'h0;
  localparam logic [7:0] PF_FLAG_SET    = 8'h66;

  // ==========================================================================
  // Pack status bit positions
  // ==========================================================================
  localparam int PS_HOST  = 7;
  localparam int PS_EOD2  = 6;
  localparam int PS_SEAL  = 5;
  localparam int PS_QLF   = 4;
  localparam int PS_AFE   = 3;
  localparam int PS_PFL   = 2;
  localparam int PS_OVER  = 1;
  localparam int PS_UNDER = 0;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [4:0]
  {
    ST_IDLE = 5'h01,
    ST_LOAD = 5'h02,
    ST_REQ  = 5'h04,
    ST_CAPT = 5'h08,
    ST_SEND = 5'h10
  } sir_state_e_t;

  typedef enum logic [2:0]
  {
    LV_FLASH  = 3'h0,
    LV_SCALE  = 3'h1,
    LV_STATUS = 3'h2,
    LV_AFE    = 3'h3,
    LV_EDV_LO = 3'h4,
    LV_EDV_HI = 3'h5,
    LV_CELL   = 3'h6,
    LV_MDLEN  = 3'h7
  } sir_live_t;

  typedef struct packed
  {
    sir_live_t  sel;
    logic       hi;
    logic [8:0] addr;
  } sir_src_t;

  typedef struct packed
  {
    logic             sealed;
    logic             end_discharge_level2;
    logic             discharge_qualified;
    logic             front_end_link_failed;
    logic [7:0]       permanent_failure;
    logic [7:0]       front_end_status;
    logic [15:0]      pending_edv;
    logic [3:0][15:0] cell_voltages;
  } sir_gauge_t;

  typedef struct packed
  {
    sir_state_e_t st;
    logic [7:0]   cmd;
    logic [4:0]   idx;
    logic [4:0]   total;
    logic [4:0]   chars;
    logic         ext;
    logic [8:0]   flash_addr;
    logic         flash_rd_en;
    logic         resp_valid;
    logic [7:0]   resp_byte;
    logic         resp_last;
    logic         resp_nack;
  } sir_regs_t;

  localparam sir_regs_t REGS_RESET = '{st: ST_IDLE, default: '0};

endpackage : sir_pkg

// ===== sir_sync.sv
// Two-stage synchroniser for asynchronous level inputs.
// Assumes inputs are slow levels; no pulse is shorter than two clocks.
`timescale 1ns/1ns
module sir_sync
#(
  parameter int WIDTH = 3
)
(
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ==========================================================================
  // Stages
  // ==========================================================================
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : sir_sync

// ===== sir_responder_checker.sv
// Concurrent checks on the identity/status responder ports.
// Assumes gauge state is held steady while a command is answered.
`timescale 1ns/1ns
module sir_responder_checker
(
  // Clock and reset
  input wire logic                sys_clk,
  input wire logic                rst,
  // Command and answer
  input wire logic                cmd_valid,
  input wire logic [7:0]          cmd_code,
  input wire logic                xfer_abort,
  input wire logic                resp_valid,
  input wire logic [7:0]          resp_byte,
  input wire logic                resp_last,
  input wire logic                resp_ready,
  input wire logic                resp_nack,
  // Flash and state
  input wire logic                flash_rd_en,
  input wire logic [8:0]          flash_addr,
  input wire logic [7:0]          flash_rd_data,
  input wire logic                cell_cmd_relocate,
  input wire sir_pkg::sir_gauge_t gauge
);
  // ==========================================================================
  // Command tracking
  // ==========================================================================
  logic       busy_q;
  logic [7:0] cmd_q;
  logic [4:0] cnt_q;
  logic       take, sel, unsel, word_cmd;
  assign take     = !busy_q && cmd_valid;
  assign sel      = cmd_code[7:2] == (cell_cmd_relocate ? 6'h0E : 6'h0F);
  assign unsel    = cmd_code[7:2] == (cell_cmd_relocate ? 6'h0F : 6'h0E);
  assign word_cmd = (cmd_q inside {8'h1A, 8'h1B, 8'h1C, 8'h2F}) || cmd_q[7:3] == 5'h07;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      {busy_q, cmd_q, cnt_q} <= '0;
    else if (xfer_abort || resp_nack || (resp_valid && resp_ready && resp_last))
      busy_q <= 1'b0;
    else if (take)
    begin
      busy_q <= 1'b1;
      cmd_q  <= cmd_code;
      cnt_q  <= 5'h00;
    end
    else if (resp_valid && resp_ready)
      cnt_q <= cnt_q + 5'h01;
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_serial_rd;
    flash_rd_en && flash_addr == sir_pkg::DF_SERIAL_LO;
  endsequence
  sequence s_flash_byte;
    resp_valid && !resp_last && resp_byte == $past(flash_rd_data);
  endsequence

  a_resp_stands: assert property (resp_valid && !resp_ready && !xfer_abort |=>
    resp_valid && $stable(resp_byte) && $stable(resp_last)) else $error("byte moved");
  a_nack_single: assert property (resp_nack |=> !resp_nack) else $error("long nack");
  a_cell_unsel_nack: assert property (take && unsel |=> resp_nack) else $error("no nack");
  a_cell_sel_ack: assert property (take && sel |=> !resp_nack ##1 !resp_nack) else $error("false nack");
  a_serial_walk: assert property (take && cmd_code == 8'h1C |-> ##2 s_serial_rd ##2 s_flash_byte)
    else $error("serial byte");
  a_spec_scale_zero: assert property (resp_valid && cmd_q == 8'h1A && cnt_q == 5'h01 |->
    resp_byte == 8'h00 && resp_last) else $error("scale not zero");
  a_status_bits: assert property (resp_valid && cmd_q == 8'h2F && cnt_q == 5'h00 |->
    resp_byte[6:2] == {gauge.end_discharge_level2, gauge.sealed, gauge.discharge_qualified,
    gauge.front_end_link_failed, gauge.permanent_failure == 8'h66}) else $error("status bits");
  a_word_end: assert property (resp_valid && word_cmd |-> resp_last == (cnt_q == 5'h01))
    else $error("word length");
  a_mfr_data_len: assert property (resp_valid && cmd_q == 8'h23 && cnt_q == 5'h00 |->
    resp_byte == 8'h0D && !resp_last) else $error("block length");
  a_abort_drop: assert property (xfer_abort |=> !resp_valid ##1 !resp_valid) else $error("kept after abort");
endmodule : sir_responder_checker

bind sir_responder sir_responder_checker u_chk (.*);

// ===== sir_host_model.sv
// Host-side model: offers commands and takes answer bytes.
// Assumes one command in flight; the bench calls its tasks.
`timescale 1ns/1ns
module sir_host_model
(
  // Clock
  input wire logic        sys_clk,
  // Command side
  output logic            cmd_valid,
  output logic [7:0]      cmd_code,
  output logic            xfer_abort,
  // Answer side
  input wire logic        resp_valid,
  input wire logic [7:0]  resp_byte,
  input wire logic        resp_last,
  output logic            resp_ready,
  input wire logic        resp_nack
);
  logic [7:0] rx[$];

  initial
  begin
    {cmd_valid, xfer_abort, resp_ready} = 3'h0;
    cmd_code = 8'hFF;
  end

  // Idle code inverted, never stale
  task automatic send_cmd(input logic [7:0] code);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_code  <= code;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    cmd_code  <= ~code;
  endtask : send_cmd

  task automatic abort_xfer();
    @(posedge sys_clk);
    xfer_abort <= 1'b1;
    @(posedge sys_clk);
    xfer_abort <= 1'b0;
  endtask : abort_xfer

  // Stall: cycles before ready
  task automatic collect(input int stall, output logic nacked, output int ok);
    int n = 0;
    int w;
    rx.delete();
    nacked = 1'b0;
    for (w = 0; w < 300; w++)
    begin
      @(posedge sys_clk);
      if (resp_nack)
      begin
        nacked = 1'b1;
        break;
      end
      if (resp_valid && resp_ready)
      begin
        rx.push_back(resp_byte);
        resp_ready <= 1'b0;
        n = 0;
        if (resp_last)
          break;
      end
      else if (resp_valid)
      begin
        if (n >= stall)
          resp_ready <= 1'b1;
        n++;
      end
    end
    ok = int'(w < 300);
  endtask : collect

  function automatic logic same_text(input logic [7:0] a, input logic [7:0] b);
    return (a | 8'h20) == (b | 8'h20);
  endfunction : same_text
endmodule : sir_host_model

// ===== sir_responder_tb_top.sv
// Self-checking bench for the identity/status responder.
// Assumes a one-cycle flash model and the host model beside it.
`timescale 1ns/1ns
module sir_responder_tb_top;
  typedef struct packed { logic [7:0] code; logic ext; logic [3:0] stall; } sir_row_t;
  logic                sys_clk, rst, cmd_valid, xfer_abort, resp_valid, resp_last, resp_ready;
  logic                resp_nack, flash_rd_en, ext_en, reloc, pack_inserted, over, under;
  logic [7:0]          cmd_code, resp_byte, p;
  logic [7:0]          flash_rd_data = 8'h00;
  logic [8:0]          flash_addr;
  logic [15:0]         w;
  logic [31:0]         nm;
  sir_pkg::sir_gauge_t gauge;
  logic [7:0]          fl [0:511];
  logic [7:0]          exp[$];
  int                  err_total, checks, i, k;
  sir_row_t rows [10] = '{'{8'h1A, 1'b0, 4'h1}, '{8'h1B, 1'b0, 4'h0}, '{8'h1C, 1'b0, 4'h2},
    '{8'h20, 1'b0, 4'h0}, '{8'h20, 1'b1, 4'h3}, '{8'h21, 1'b0, 4'h0}, '{8'h21, 1'b1, 4'h1},
    '{8'h22, 1'b0, 4'h0}, '{8'h23, 1'b0, 4'h2}, '{8'h2F, 1'b0, 4'h0}};

  sir_responder uut
  (
    .*, .extended_string_enable(ext_en), .cell_cmd_relocate(reloc), .pack_inserted_pin(pack_inserted),
    .secondary_over_fault_pin(over), .secondary_under_fault_pin(under)
  );
  sir_host_model u_host (.*);

  // Flash lines toggle outside read slot
  always @(posedge sys_clk)
    flash_rd_data <= flash_rd_en ? fl[flash_addr] : ~flash_rd_data;

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic finish_test();
    if (err_total == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  task automatic ck(input logic [15:0] seen, input logic [15:0] want);
    checks++;
    if (seen !== want)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
    end
  endtask : ck

  task automatic build(input logic [7:0] c);
    logic [8:0] b;
    logic [8:0] xb;
    logic [4:0] mx;
    logic [4:0] n;
    exp.delete();
    {b, xb, mx} = '0;
    case (c)
      8'h1A: exp = '{fl[9'h007], 8'h00};
      8'h1B: exp = '{fl[9'h009], fl[9'h008]};
      8'h1C: exp = '{fl[9'h00B], fl[9'h00A]};
      8'h20: {b, xb, mx} = {9'h00E, 9'h151, 5'h0B};
      8'h21: {b, xb, mx} = {9'h01A, 9'h141, 5'h07};
      8'h22: {b, xb, mx} = {9'h022, 9'h000, 5'h04};
      8'h23:
      begin
        exp = '{8'h0D};
        for (int j = 0; j < 10; j++)
          exp.push_back(fl[9'h028 + j]);
        exp = {exp, gauge.front_end_status, gauge.pending_edv[7:0], gauge.pending_edv[15:8]};
      end
      8'h2F: exp = '{{pack_inserted, gauge.end_discharge_level2, gauge.sealed, gauge.discharge_qualified,
        gauge.front_end_link_failed, gauge.permanent_failure == 8'h66, over, under}, fl[9'h028]};
      default:
        if (c[7:2] == (reloc ? 6'h0E : 6'h0F))
          exp = '{gauge.cell_voltages[~c[1:0]][7:0], gauge.cell_voltages[~c[1:0]][15:8]};
    endcase
    if (mx != 5'h00)
    begin
      n = (fl[b] > 8'(mx)) ? mx : fl[b][4:0];
      exp.push_back(8'(n + ((ext_en && xb != 9'h000) ? 5'h0F : 5'h00)));
      for (int j = 1; j <= n; j++)
        exp.push_back(fl[b + j]);
      for (int j = 0; ext_en && xb != 9'h000 && j < 15; j++)
        exp.push_back(fl[xb + j]);
    end
  endtask : build

  task automatic check_rx(input logic [7:0] c, input int stall);
    logic nk;
    int   ok;
    u_host.collect(stall, nk, ok);
    ck(16'(ok), 16'h0001);
    if (ok == 0)
      finish_test();
    build(c);
    ck(16'(nk), 16'(exp.size() == 0));
    ck(16'(u_host.rx.size()), 16'(exp.size()));
    foreach (exp[j])
      ck(16'(u_host.rx[j]), 16'(exp[j]));
  endtask : check_rx

  task automatic run(input logic [7:0] c, input int stall);
    u_host.send_cmd(c);
    check_rx(c, stall);
  endtask : run

  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial
  begin
    rst = 1'b1;
    {ext_en, reloc, pack_inserted, over, under} = 5'h00;
    gauge = '0;
    gauge.front_end_status = 8'h5A;
    gauge.pending_edv = 16'h0BB8;
    gauge.cell_voltages = {16'h0F01, 16'h0E02, 16'h0D03, 16'h0C04};
    for (i = 0; i < 512; i++)
      fl[i] = 8'(i * 7 + 3);
    {fl[9'h006], fl[9'h007]} = 16'h1231;
    {fl[9'h008], fl[9'h009]} = 16'((2003 - 1980) * 512 + 1 * 32 + 1);
    {fl[9'h00E], fl[9'h01A], fl[9'h022]} = 24'h0D0704;
    {fl[9'h023], fl[9'h024], fl[9'h025], fl[9'h026]} = 32'h4C694F6E;
    repeat (16) @(posedge sys_clk);
    ck(16'({resp_valid, resp_nack, flash_rd_en, resp_last}), 16'h0000);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      ext_en <= rows[i].ext;
      run(rows[i].code, rows[i].stall);
    end
    for (i = 0; i < 16; i++)
    begin
      reloc <= i[3];
      run(8'h38 + 8'(i[2:0]), i % 3);
    end
    // Offer while busy: ignored
    u_host.send_cmd(8'h1C);
    u_host.send_cmd(8'h3F);
    check_rx(8'h1C, 1);
    run(8'h1B, 0);
    w = {u_host.rx[1], u_host.rx[0]};
    ck(16'(w[4:0]), 16'h0001);
    ck(16'(w[8:5]), 16'h0001);
    ck(16'(w[15:9]), 16'(2003 - 1980));
    nm = "lion";
    run(8'h22, 0);
    for (k = 1; k <= 4; k++)
      ck(16'(u_host.same_text(u_host.rx[k], nm[39 - 8 * k -: 8])), 16'h0001);
    for (i = 0; i <= 8; i++)
    begin
      p = (i == 8) ? 8'h00 : 8'h01 << i;
      {pack_inserted, gauge.end_discharge_level2, gauge.sealed, gauge.discharge_qualified, gauge.front_end_link_failed} <= p[7:3];
      gauge.permanent_failure <= p[2] ? 8'h66 : 8'h00;
      {over, under} <= p[1:0];
      repeat (4) @(posedge sys_clk);
      run(8'h2F, 0);
      ck(16'(u_host.rx[0]), 16'(p));
    end
    ext_en <= 1'b1;
    u_host.send_cmd(8'h20);
    repeat (8) @(posedge sys_clk);
    u_host.abort_xfer();
    @(posedge sys_clk);
    ck(16'(resp_valid), 16'h0000);
    run(8'h21, 0);
    u_host.send_cmd(8'h23);
    repeat (5) @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    ck(16'({resp_valid, resp_nack, flash_rd_en}), 16'h0000);
    rst <= 1'b0;
    run(8'h1A, 0);
    finish_test();
  end
endmodule : sir_responder_tb_top
